// ---- hdl/tfcdp_top.sv ----
// target configuration download port: loads a stored stream into targets
// assumes the stream store answers a word request in the next cycle
//
// Notes on behaviour
// - in serial mode each data bit n carries the stream of chain n.
// - in parallel mode the data bits form one byte bus shared by all targets.
// - a three-bit mode output drives the mode pins of all targets.
// - the load clock is the system clock divided by two and goes to every target.
// - each download opens with a low pulse on the reconfiguration output.
// - no data is sent until the ready sense has been seen high after the pulse.
// - while stall is high the data holds and the word does not advance.
// - the completion input is the shared done state of all targets.
// - in parallel mode the direction output shows write during delivery.
// - four active-low selects each enable one parallel target.
// - reset is held for ten cycles and its release starts the download.
// - a three-bit input chooses one of eight stored streams.
// - all download logic runs on the single system clock.
`timescale 1ns/1ps
module tfcdp_top
(
  input  wire logic        sys_clk_i,        // system clock, 100 MHz
  input  wire logic        rst_i,            // synchronous reset, active high
  input  wire logic        parallel_mode_i,  // 1 = byte-wide, 0 = serial chains
  input  wire logic [2:0]  stream_select_i,  // stored stream number
  input  wire logic [3:0]  target_enable_i,  // parallel targets present
  input  wire logic        ready_sense_i,    // target ready-for-data pin
  input  wire logic        stall_sense_i,    // target stall pin
  input  wire logic        completion_sense_i, // shared completion pin
  input  wire logic [7:0]  stream_data_i,    // word from the stream store
  input  wire logic        stream_last_i,    // word is the last of the stream
  output logic             stream_req_o,     // fetch next word, one-cycle pulse
  output logic [2:0]       stream_sel_o,     // stream being fetched
  output logic [7:0]       target_load_bits_o, // data pins to targets
  output logic [2:0]       target_mode_o,    // mode pins of all targets
  output logic             load_clock_o,     // load clock to targets
  output logic             target_reconfig_n_o, // reconfiguration pulse, low active
  output logic             target_direction_n_o, // direction, low = write
  output logic [3:0]       target_select_n_o, // per-target selects, low active
  output logic             busy_o,           // download in progress
  output logic             done_o            // download finished
);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROG,
    ST_WAIT_READY,
    ST_FETCH,
    ST_SHIFT,
    ST_FINISH
  } tfcdp_state_t;

  typedef struct packed {
    tfcdp_state_t state;
    logic         clk_div;
    logic [15:0]  cnt;
    logic [7:0]   data;
    logic [7:0]   shreg;
    logic         last;
    logic         par;
    logic [2:0]   sel;
    logic         prog_n;
    logic         req;
    logic         done;
  } tfcdp_regs_t;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic ready_s;
  logic stall_s;
  logic done_s;

  tfcdp_sync u_sync_ready
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (ready_sense_i),
    .sync_o    (ready_s)
  );

  tfcdp_sync u_sync_stall
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (stall_sense_i),
    .sync_o    (stall_s)
  );

  tfcdp_sync u_sync_done
  (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (completion_sense_i),
    .sync_o    (done_s)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  tfcdp_regs_t regs_r;
  tfcdp_regs_t regs_nxt;
  logic        fall_edge;

  // data changes as the load clock falls, targets sample on its rising edge
  assign fall_edge = regs_r.clk_div;

  always_comb
  begin
    regs_nxt         = regs_r;
    regs_nxt.req     = 1'b0;
    regs_nxt.clk_div = ~regs_r.clk_div;
    case (regs_r.state)
      ST_IDLE:
      begin
        // reset release starts the download, mode and stream latched here
        regs_nxt.par    = parallel_mode_i;
        regs_nxt.sel    = stream_select_i;
        regs_nxt.prog_n = 1'b0;
        regs_nxt.cnt    = 16'(tfcdp_pkg::PROG_PULSE_CYC - 1);
        regs_nxt.done   = 1'b0;
        regs_nxt.state  = ST_PROG;
      end
      ST_PROG:
      begin
        if (regs_r.cnt == 16'h0000)
        begin
          regs_nxt.prog_n = 1'b1;
          regs_nxt.state  = ST_WAIT_READY;
        end
        else
        begin
          regs_nxt.cnt = regs_r.cnt - 16'h0001;
        end
      end
      ST_WAIT_READY:
      begin
        if (ready_s)
        begin
          regs_nxt.req   = 1'b1;
          regs_nxt.state = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        // word arrives the cycle after the request
        regs_nxt.shreg   = stream_data_i;
        regs_nxt.last    = stream_last_i;
        regs_nxt.state   = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (done_s)
        begin
          regs_nxt.done  = 1'b1;
          regs_nxt.state = ST_FINISH;
        end
        else if (fall_edge && !stall_s)
        begin
          if (regs_r.par)
          begin
            regs_nxt.data = regs_r.shreg;
            regs_nxt.state = regs_r.last ? ST_FINISH : ST_FETCH;
            regs_nxt.req   = !regs_r.last;
          end
          else
          begin
            // one bit per chain per load clock: bit n of each word belongs to chain n
            regs_nxt.data = regs_r.shreg;
            regs_nxt.state = regs_r.last ? ST_FINISH : ST_FETCH;
            regs_nxt.req   = !regs_r.last;
          end
        end
      end
      ST_FINISH:
      begin
        if (done_s)
        begin
          regs_nxt.done = 1'b1;
        end
      end
      default:
      begin
        regs_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      regs_r.state   <= ST_IDLE;
      regs_r.clk_div <= 1'b0;
      regs_r.cnt     <= 16'h0000;
      regs_r.data    <= tfcdp_pkg::DATA_RST;
      regs_r.shreg   <= tfcdp_pkg::DATA_RST;
      regs_r.last    <= 1'b0;
      regs_r.par     <= 1'b0;
      regs_r.sel     <= 3'h0;
      regs_r.prog_n  <= 1'b1;
      regs_r.req     <= 1'b0;
      regs_r.done    <= 1'b0;
    end
    else
    begin
      regs_r <= regs_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic delivering;
  assign delivering = (regs_r.state == ST_FETCH) || (regs_r.state == ST_SHIFT);

  assign stream_req_o         = regs_r.req;
  assign stream_sel_o         = regs_r.sel;
  assign target_load_bits_o   = regs_r.data;
  assign target_mode_o        = regs_r.par ? tfcdp_pkg::MODE_PARALLEL
                                           : tfcdp_pkg::MODE_SERIAL;
  assign load_clock_o         = regs_r.clk_div;
  assign target_reconfig_n_o  = regs_r.prog_n;
  assign target_direction_n_o = !(regs_r.par && delivering);
  assign target_select_n_o    = (regs_r.par && delivering) ? ~target_enable_i
                                                           : tfcdp_pkg::SELECT_IDLE_N;
  assign busy_o               = (regs_r.state != ST_FINISH);
  assign done_o               = regs_r.done;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence prog_low_s;
    !target_reconfig_n_o;
  endsequence

  // the first edge after reset has no earlier toggle to compare against
  property clock_toggle_p;
    @(posedge sys_clk_i) disable iff (rst_i)
      !$past(rst_i) |-> (load_clock_o != $past(load_clock_o));
  endproperty
  clock_half_rate_a : assert property (clock_toggle_p)
    else $error("load clock did not toggle");

  prog_pulse_low_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(regs_r.state == ST_PROG) |-> prog_low_s [*8])
    else $error("reconfiguration pulse too short");

  ready_gate_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.state == ST_WAIT_READY && !ready_s) |=> !stream_req_o)
    else $error("data fetched before ready");

  stall_hold_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (stall_s && regs_r.state == ST_SHIFT && !done_s) |=> $stable(target_load_bits_o))
    else $error("data changed during stall");

  mode_const_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.state != ST_IDLE && $past(regs_r.state) != ST_IDLE)
      |-> $stable(target_mode_o))
    else $error("mode changed during download");

  done_stop_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (done_s && regs_r.state == ST_SHIFT) |=> (done_o && !stream_req_o))
    else $error("delivery after completion");

  dir_write_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.par && regs_r.state == ST_SHIFT) |-> !target_direction_n_o)
    else $error("direction not write while delivering");

  select_idle_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.state == ST_WAIT_READY) |-> (target_select_n_o == 4'hF))
    else $error("target selected outside delivery");

  reset_start_a : assert property (@(posedge sys_clk_i)
    $fell(rst_i) |-> ##1 !target_reconfig_n_o)
    else $error("download not started after reset");

  shift_on_high_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.state == ST_SHIFT && !regs_r.clk_div) |=> $stable(target_load_bits_o))
    else $error("data changed while load clock low");

  ready_fetch_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.state == ST_WAIT_READY && ready_s) |=> stream_req_o)
    else $error("no fetch after ready");

  finish_quiet_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.state == ST_FINISH) |=> (!stream_req_o && $stable(target_load_bits_o)))
    else $error("delivery after finish");

  select_on_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.par && regs_r.state == ST_SHIFT) |-> (target_select_n_o == ~target_enable_i))
    else $error("enabled target not selected");

  reconfig_idle_a : assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (regs_r.state == ST_WAIT_READY) |-> target_reconfig_n_o)
    else $error("reconfiguration held past its pulse");

endmodule

// ---- hdl/tfcdp_pkg.sv ----
// package for the target configuration download port
// assumes a 100 MHz system clock and a synchronous active-high reset
package tfcdp_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int PROG_PULSE_NS     = 500;
  localparam int PROG_PULSE_CYC    = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_CYC     = 10;
  localparam int SYNC_STAGES       = 2;

  // ----------------------------------------
  // data layout
  // ----------------------------------------
  localparam int DATA_W            = 8;
  localparam int MODE_W            = 3;
  localparam int SEL_W             = 3;
  localparam int NUM_TARGETS       = 4;
  localparam int WORD_CNT_W        = 16;

  // ----------------------------------------
  // target mode pin encodings
  // ----------------------------------------
  localparam logic [2:0] MODE_SERIAL   = 3'h7;
  localparam logic [2:0] MODE_PARALLEL = 3'h6;

  // ----------------------------------------
  // reset values of pins
  // ----------------------------------------
  localparam logic [7:0] DATA_RST      = 8'h00;
  localparam logic [3:0] SELECT_IDLE_N = 4'hF;

endpackage

// ---- hdl/tfcdp_sync.sv ----
// two-stage synchroniser for one asynchronous level
// assumes the input comes from a pin outside the system clock domain
`timescale 1ns/1ps
module tfcdp_sync
(
  input  wire logic sys_clk_i,  // system clock
  input  wire logic rst_i,      // synchronous reset
  input  wire logic async_i,    // level from a pin
  output logic      sync_o      // synchronised level
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// ---- dv/tfcdp_target_model.sv ----
// model of the targets: ready, stall and completion lines
// assumes one system clock; stall and completion follow bench commands
`timescale 1ns/1ps
module tfcdp_target_model
#(
  parameter int READY_DLY = 8
)
(
  input  wire logic sys_clk_i,    // system clock
  input  wire logic reconfig_n_i, // reconfiguration pulse from the port
  input  wire logic stall_cmd_i,  // bench asks for a stall
  input  wire logic done_cmd_i,   // bench asks for completion
  output logic      ready_o,      // ready for data
  output logic      stall_o,      // stall pin
  output logic      completion_o  // shared completion line
);
  int cnt = 0;

  initial ready_o = 1'b0;

  // ready drops while the pulse is low and returns some cycles after it ends
  always @(posedge sys_clk_i)
  begin
    cnt     <= reconfig_n_i ? cnt + 1 : 0;
    ready_o <= reconfig_n_i && (cnt >= READY_DLY);
  end

  assign stall_o      = stall_cmd_i;
  // the completion line follows the bench command directly
  assign completion_o = done_cmd_i;
endmodule

// ---- dv/tfcdp_bench.sv ----
// self-checking bench for the download port
// assumes stream store and targets are modelled here on one 100 MHz clock
`timescale 1ns/1ps
module tfcdp_bench;
  typedef struct {logic par; logic [2:0] sel; logic [3:0] en; logic [7:0] word;} tfcdp_row_t;
  localparam int RDY = 8;
  logic       sys_clk   = 1'b0;
  logic       rst       = 1'b1;
  logic       par       = 1'b0;
  logic [2:0] sel       = 3'h0;
  logic [3:0] en        = 4'h0;
  logic       stall_cmd = 1'b0;
  logic       done_cmd  = 1'b0;
  logic [7:0] sdata     = 8'h00;
  logic [7:0] nxt       = 8'h00;
  logic       ready, stall, compl, req, lclk, rcfg_n, dir_n, busy, done;
  logic [2:0] ssel, mode;
  logic [7:0] bits, snap;
  logic [3:0] cs_n;
  int         n_errors  = 0;
  int         n_tests   = 0;
  tfcdp_row_t rows [4]  = '{'{1'b1, 3'h0, 4'hF, 8'hA5}, '{1'b1, 3'h5, 4'h6, 8'h3C},
                           '{1'b0, 3'h7, 4'h9, 8'h81}, '{1'b0, 3'h2, 4'h0, 8'hFE}};

  always #5 sys_clk = ~sys_clk;

  // stream store: answers a request in the next cycle with sequential words
  always @(negedge sys_clk)
    if (req === 1'b1)
    begin
      sdata <= nxt;
      nxt   <= nxt + 8'h01;
    end

  tfcdp_top u_tfcdp_top (.sys_clk_i(sys_clk), .rst_i(rst), .parallel_mode_i(par),
    .stream_select_i(sel), .target_enable_i(en), .ready_sense_i(ready),
    .stall_sense_i(stall), .completion_sense_i(compl), .stream_data_i(sdata),
    .stream_last_i(1'b0), .stream_req_o(req), .stream_sel_o(ssel),
    .target_load_bits_o(bits), .target_mode_o(mode), .load_clock_o(lclk),
    .target_reconfig_n_o(rcfg_n), .target_direction_n_o(dir_n),
    .target_select_n_o(cs_n), .busy_o(busy), .done_o(done));

  tfcdp_target_model #(.READY_DLY(RDY)) u_tfcdp_target_model (.sys_clk_i(sys_clk),
    .reconfig_n_i(rcfg_n), .stall_cmd_i(stall_cmd), .done_cmd_i(done_cmd),
    .ready_o(ready), .stall_o(stall), .completion_o(compl));

  task automatic check_bits(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_num(input int got, input int exp, input string what);
    check_bits(8'(got), 8'(exp), what);
  endtask

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // reset, then one download up to its first delivered word
  task automatic run_row(input tfcdp_row_t r);
    int   k;
    logic prev;
    rst = 1'b1;
    par = r.par;
    sel = r.sel;
    en = r.en;
    stall_cmd = 1'b0;
    done_cmd = 1'b0;
    repeat (10) @(negedge sys_clk);
    // store restarts while reset holds the request low
    nxt = r.word;
    check_bits({bits[3:0], cs_n}, 8'h0F, "reset data and selects");
    check_bits({5'h00, lclk, rcfg_n, req}, 8'h02, "reset controls");
    rst = 1'b0;
    k = 0;
    while (rcfg_n !== 1'b0 && k < 20)
    begin
      @(negedge sys_clk);
      k++;
    end
    k = 0;
    while (rcfg_n === 1'b0 && k < 200)
    begin
      @(negedge sys_clk);
      k++;
    end
    check_num(k, tfcdp_pkg::PROG_PULSE_CYC, "pulse length");
    k = 0;
    while (req !== 1'b1 && k < 100)
    begin
      @(negedge sys_clk);
      k++;
    end
    check_num(int'(k >= RDY && k < 100), 1, "request after ready");
    k = 0;
    while (bits !== r.word && k < 8)
    begin
      @(negedge sys_clk);
      k++;
    end
    check_bits(bits, r.word, "first word");
    check_bits(8'(ssel), 8'(r.sel), "stream select");
    check_bits({4'h0, cs_n}, r.par ? {4'h0, ~r.en} : 8'h0F, "selects");
    check_bits(8'(dir_n), 8'(!r.par), "direction");
    check_bits({7'h00, busy}, 8'h01, "busy while loading");
    for (int i = 0; i < 6; i++)
    begin
      prev = lclk;
      @(negedge sys_clk);
      check_bits({7'h00, lclk}, {7'h00, !prev}, "load clock");
      check_bits({5'h00, mode},
                 {5'h00, r.par ? tfcdp_pkg::MODE_PARALLEL : tfcdp_pkg::MODE_SERIAL},
                 "mode");
    end
    $display("row done at %0t", $time);
  endtask

  initial
  begin
    foreach (rows[i])
      run_row(rows[i]);
    run_row(rows[0]);
    stall_cmd = 1'b1;
    repeat (4) @(negedge sys_clk);
    snap = bits;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge sys_clk);
      check_bits(bits, snap, "held under stall");
      check_bits({7'h00, req}, 8'h00, "no fetch under stall");
    end
    stall_cmd = 1'b0;
    for (int i = 0; i < 20 && bits === snap; i++)
      @(negedge sys_clk);
    check_bits(bits, snap + 8'h01, "word after stall");
    $display("stall test done at %0t", $time);
    done_cmd = 1'b1;
    for (int i = 0; i < 8 && done !== 1'b1; i++)
      @(negedge sys_clk);
    check_bits(8'(done), 8'h01, "done");
    for (int i = 0; i < 20; i++)
    begin
      @(negedge sys_clk);
      check_bits({6'h00, req, busy}, 8'h00, "stopped after done");
    end
    $display("completion test done at %0t", $time);
    results();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    results();
  end
endmodule
